// file: verilog/data_path_state_reporting.sv
// data path state machine with lane state reporting and change flags
`include "dp_status_consts.svh"
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - path state machine only gates rx output until first initialization completes.
// - after initialization, valid rx input is forwarded in working states unless muted.
// - in deinit, ground or initializing states rx output keeps forwarding.
// - host rx mute bit always mutes that lane's rx output.
// - enabled auto squelch with squelch condition mutes the lane output.
// - rx output status shows the real output, independent of path state.
// - lane request bit 0 asks initialization, 1 asks deinitialization.
// - one write may change several paths' bits; every path reacts.
// - one cycle after state entry the state code goes to every lane of the path.
// - reporting is skipped only for states left at once; briefly held states are reported.
// - a state change indication sets the flag on all lanes of the path.
// - a transient time code of zero is insignificant, others significant.
// - steady entry flags only if not exiting and a significant transient passed.
// - flag set only entering initialized, ground or activated states.
// - state changes never clear flags.
// - in ground state all tx lane outputs of the path are quiescent.
// - deinit signal is not ready, or low power, or any lane request bit.
// - ground state goes to initializing when deinit signal false and not reset.
module data_path_state_reporting #(
	parameter int LANES      = 8,
	parameter int PATH_LANES = 2,
	parameter int SHORT_CYC  = `DP_SHORT_STATE_CYC
) (
	// clock and reset
	input  wire logic                        clk_i,
	input  wire logic                        srst_i,
	// module level terms
	input  wire logic                        module_is_ready_term_i,
	input  wire logic                        low_power_signal_i,
	// host lane controls
	input  wire logic [LANES-1:0]            lane_deinit_request_i,
	input  wire logic [LANES-1:0]            tx_output_off_ctrl_i,
	input  wire logic [LANES-1:0]            tx_forced_squelch_ctrl_i,
	input  wire logic [LANES-1:0]            rx_output_mute_ctrl_i,
	input  wire logic [LANES-1:0]            auto_squelch_en_i,
	input  wire logic [LANES-1:0]            state_changed_flag_clr_i,
	// advertised transient durations
	input  wire logic [3:0]                  max_time_init_i,
	input  wire logic [3:0]                  max_time_deinit_i,
	input  wire logic [3:0]                  max_time_turn_on_i,
	input  wire logic [3:0]                  max_time_turn_off_i,
	// path resource completion from the datapath electronics
	input  wire logic [LANES-1:0]            init_done_i,
	input  wire logic [LANES-1:0]            deinit_done_i,
	input  wire logic [LANES-1:0]            turn_on_done_i,
	input  wire logic [LANES-1:0]            turn_off_done_i,
	// rx pins
	input  wire logic [LANES-1:0]            rx_valid_in_i,
	input  wire logic [LANES-1:0]            squelch_cond_i,
	output logic      [LANES-1:0]            rx_valid_out_o,
	output logic      [LANES-1:0]            rx_output_actual_status_o,
	// tx enables and status
	output logic      [LANES-1:0]            tx_output_enable_o,
	output logic      [LANES*4-1:0]          lane_current_state_field_o,
	output logic      [LANES-1:0]            state_changed_flag_o
);

	localparam int PATHS = LANES / PATH_LANES;
	localparam int CW    = $clog2(SHORT_CYC + 1);

	logic [LANES-1:0] rx_valid_sync;
	logic [LANES-1:0] squelch_sync;

	sync2 #(.WIDTH(LANES)) u_sync_rx (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.d_i    (rx_valid_in_i),
		.q_o    (rx_valid_sync)
	);

	sync2 #(.WIDTH(LANES)) u_sync_sq (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.d_i    (squelch_cond_i),
		.q_o    (squelch_sync)
	);

	function automatic logic [3:0] state_code(input dp_status_pkg::path_state_t s);
		case (s)
			dp_status_pkg::ST_GROUND:       state_code = `DP_CODE_GROUND;
			dp_status_pkg::ST_INITIALIZING: state_code = `DP_CODE_INITIALIZING;
			dp_status_pkg::ST_INITIALIZED:  state_code = `DP_CODE_INITIALIZED;
			dp_status_pkg::ST_DEINIT:       state_code = `DP_CODE_DEINIT;
			dp_status_pkg::ST_TURNING_ON:   state_code = `DP_CODE_TURNING_ON;
			dp_status_pkg::ST_ACTIVATED:    state_code = `DP_CODE_ACTIVATED;
			dp_status_pkg::ST_TURNING_OFF:  state_code = `DP_CODE_TURNING_OFF;
			default:                        state_code = `DP_CODE_GROUND;
		endcase
	endfunction

	genvar p;
	genvar l;
	generate
		for (p = 0; p < PATHS; p++) begin : g_path
			dp_status_pkg::path_state_t state_reg;
			dp_status_pkg::path_state_t state_next;
			logic [PATH_LANES-1:0]      req;
			logic [PATH_LANES-1:0]      txoff;
			logic [PATH_LANES-1:0]      txsq;
			logic                       deinit_sig;
			logic                       deactivate_sig;
			logic                       init_done;
			logic                       deinit_done;
			logic                       on_done;
			logic                       off_done;
			logic                       entering;
			logic                       steady_entry;
			logic                       stays;
			logic                       transient_sig;
			logic                       signif_reg;
			logic                       rx_ready_reg;
			logic                       fwd_state;
			logic                       indicate;
			logic [3:0]                 report_reg;
			logic [3:0]                 pend_code_reg;
			logic                       pend_reg;
			logic [CW-1:0]              dwell_reg;
			logic [3:0]                 cur_time_code;

			assign req   = lane_deinit_request_i[p*PATH_LANES +: PATH_LANES];
			assign txoff = tx_output_off_ctrl_i[p*PATH_LANES +: PATH_LANES];
			assign txsq  = tx_forced_squelch_ctrl_i[p*PATH_LANES +: PATH_LANES];
			assign init_done   = init_done_i[p*PATH_LANES];
			assign deinit_done = deinit_done_i[p*PATH_LANES];
			assign on_done     = turn_on_done_i[p*PATH_LANES];
			assign off_done    = turn_off_done_i[p*PATH_LANES];

			// each path reads only its own slice, so one write hits many paths
			assign deinit_sig = ~module_is_ready_term_i
				| low_power_signal_i | (|req);
			assign deactivate_sig = deinit_sig | (|txoff) | (|txsq);

			always_comb begin
				state_next = state_reg;
				case (state_reg)
					dp_status_pkg::ST_GROUND:
						if (!deinit_sig) state_next = dp_status_pkg::ST_INITIALIZING;
					dp_status_pkg::ST_INITIALIZING:
						if (deinit_sig) state_next = dp_status_pkg::ST_DEINIT;
						else if (init_done) state_next = dp_status_pkg::ST_INITIALIZED;
					dp_status_pkg::ST_INITIALIZED:
						if (deinit_sig) state_next = dp_status_pkg::ST_DEINIT;
						else if (!deactivate_sig) state_next = dp_status_pkg::ST_TURNING_ON;
					dp_status_pkg::ST_DEINIT:
						if (deinit_done) state_next = dp_status_pkg::ST_GROUND;
					dp_status_pkg::ST_TURNING_ON:
						if (deactivate_sig) state_next = dp_status_pkg::ST_TURNING_OFF;
						else if (on_done) state_next = dp_status_pkg::ST_ACTIVATED;
					dp_status_pkg::ST_ACTIVATED:
						if (deactivate_sig) state_next = dp_status_pkg::ST_TURNING_OFF;
					dp_status_pkg::ST_TURNING_OFF:
						if (off_done) state_next = dp_status_pkg::ST_INITIALIZED;
					default:
						state_next = dp_status_pkg::ST_GROUND;
				endcase
			end

			assign entering = (state_next != state_reg);
			assign transient_sig = (state_next == dp_status_pkg::ST_INITIALIZING)
				| (state_next == dp_status_pkg::ST_DEINIT)
				| (state_next == dp_status_pkg::ST_TURNING_ON)
				| (state_next == dp_status_pkg::ST_TURNING_OFF);
			assign steady_entry = entering & ~transient_sig;

			// conditions for staying in the steady state about to be entered
			assign stays = (state_next == dp_status_pkg::ST_GROUND) ? deinit_sig :
				(state_next == dp_status_pkg::ST_ACTIVATED) ? ~deactivate_sig :
				(~deinit_sig & deactivate_sig);

			assign cur_time_code =
				(state_reg == dp_status_pkg::ST_INITIALIZING) ? max_time_init_i :
				(state_reg == dp_status_pkg::ST_DEINIT)       ? max_time_deinit_i :
				(state_reg == dp_status_pkg::ST_TURNING_ON)   ? max_time_turn_on_i :
				(state_reg == dp_status_pkg::ST_TURNING_OFF)  ? max_time_turn_off_i :
				`DP_INSIGNIFICANT_CODE;

			// leaving a transient with a nonzero code counts as significant
			assign indicate = steady_entry & stays
				& (signif_reg | (entering & (cur_time_code != `DP_INSIGNIFICANT_CODE)));

			assign fwd_state = (state_reg == dp_status_pkg::ST_INITIALIZED)
				| (state_reg == dp_status_pkg::ST_TURNING_ON)
				| (state_reg == dp_status_pkg::ST_TURNING_OFF)
				| (state_reg == dp_status_pkg::ST_ACTIVATED);

			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					state_reg <= dp_status_pkg::ST_GROUND;
				end else begin
					state_reg <= state_next;
				end
			end

			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					signif_reg <= 1'b0;
				end else if (indicate) begin
					signif_reg <= 1'b0;
				end else if (entering && cur_time_code != `DP_INSIGNIFICANT_CODE) begin
					signif_reg <= 1'b1;
				end
			end

			// rx resources are ready after the first completed initialization
			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					rx_ready_reg <= 1'b0;
				end else if (state_reg == dp_status_pkg::ST_INITIALIZING && init_done
					&& !deinit_sig) begin
					rx_ready_reg <= 1'b1;
				end
			end

			// a state is reported one cycle after entry, except one left within that cycle;
			// short dwell hiding is not used, so the host sees every lasting state
			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					report_reg    <= `DP_CODE_GROUND;
					pend_code_reg <= `DP_CODE_GROUND;
					pend_reg      <= 1'b0;
					dwell_reg     <= '0;
				end else if (entering) begin
					pend_code_reg <= state_code(state_next);
					pend_reg      <= 1'b1;
					dwell_reg     <= '0;
				end else if (pend_reg) begin
					report_reg <= pend_code_reg;
					pend_reg   <= 1'b0;
					if (dwell_reg != CW'(SHORT_CYC)) begin
						dwell_reg <= dwell_reg + 1'b1;
					end
				end
			end

			for (l = 0; l < PATH_LANES; l++) begin : g_lane
				localparam int LN = p * PATH_LANES + l;
				logic flag_reg;

				// set wins over a clear in the same cycle
				always_ff @(posedge clk_i) begin
					if (srst_i) begin
						flag_reg <= 1'b0;
					end else if (indicate) begin
						flag_reg <= 1'b1;
					end else if (state_changed_flag_clr_i[LN]) begin
						flag_reg <= 1'b0;
					end
				end

				assign state_changed_flag_o[LN] = flag_reg;
				assign lane_current_state_field_o[LN*4 +: 4] = report_reg;
				assign tx_output_enable_o[LN] =
					(state_reg == dp_status_pkg::ST_ACTIVATED) ||
					(state_reg == dp_status_pkg::ST_INITIALIZED && !txoff[l] && !txsq[l]) ||
					(state_reg == dp_status_pkg::ST_TURNING_ON) ||
					(state_reg == dp_status_pkg::ST_TURNING_OFF && !txoff[l] && !txsq[l]);
				// ground, initializing and deinit leave tx quiescent

				rx_lane_out u_rx (
					.clk_i                     (clk_i),
					.srst_i                    (srst_i),
					.rx_resources_ready_i      (rx_ready_reg),
					.forwarding_state_i        (fwd_state),
					.rx_output_mute_ctrl_i     (rx_output_mute_ctrl_i[LN]),
					.auto_squelch_en_i         (auto_squelch_en_i[LN]),
					.squelch_cond_i            (squelch_sync[LN]),
					.rx_valid_in_i             (rx_valid_sync[LN]),
					.rx_valid_out_o            (rx_valid_out_o[LN]),
					.rx_output_actual_status_o (rx_output_actual_status_o[LN])
				);
			end
		end
	endgenerate

endmodule

`default_nettype wire

// file: verilog/dp_status_consts.svh
// constants for the data path status block
`ifndef DP_STATUS_CONSTS_SVH
`define DP_STATUS_CONSTS_SVH

// reported state codes, four bits per lane
`define DP_CODE_GROUND        4'h1
`define DP_CODE_INITIALIZING  4'h2
`define DP_CODE_DEINIT        4'h3
`define DP_CODE_ACTIVATED     4'h4
`define DP_CODE_TURNING_ON    4'h5
`define DP_CODE_TURNING_OFF   4'h6
`define DP_CODE_INITIALIZED   4'h7
`define DP_CODE_WIDTH         4

// max state time code meaning insignificant
`define DP_INSIGNIFICANT_CODE 4'h0

// short-state window, only the dwell count limit; no state is suppressed
`define DP_SHORT_STATE_US     1000
`define DP_CLK_MHZ            20
`define DP_SHORT_STATE_CYC    (`DP_SHORT_STATE_US * `DP_CLK_MHZ)

`endif

// file: verilog/dp_status_pkg.sv
// types for the data path status block
package dp_status_pkg;

	typedef enum logic [2:0] {
		ST_GROUND,
		ST_INITIALIZING,
		ST_INITIALIZED,
		ST_DEINIT,
		ST_TURNING_ON,
		ST_ACTIVATED,
		ST_TURNING_OFF
	} path_state_t;

endpackage

// file: verilog/rx_lane_out.sv
// one lane of rx output forwarding, muting and status
`timescale 1ns/100ps
`default_nettype none

module rx_lane_out (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic srst_i,
	// control
	input  wire logic rx_resources_ready_i,
	input  wire logic forwarding_state_i,
	input  wire logic rx_output_mute_ctrl_i,
	input  wire logic auto_squelch_en_i,
	input  wire logic squelch_cond_i,
	// data path
	input  wire logic rx_valid_in_i,
	output logic      rx_valid_out_o,
	output logic      rx_output_actual_status_o
);

	logic rx_enable_next;
	logic rx_valid_out_reg;

	// outside forwarding states we keep forwarding once initialized
	assign rx_enable_next = rx_resources_ready_i
		& (forwarding_state_i | rx_resources_ready_i)
		& ~rx_output_mute_ctrl_i
		& ~(auto_squelch_en_i & squelch_cond_i)
		& rx_valid_in_i;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rx_valid_out_reg <= 1'b0;
		end else begin
			rx_valid_out_reg <= rx_enable_next;
		end
	end

	assign rx_valid_out_o            = rx_valid_out_reg;
	// status mirrors the real output, not the path state
	assign rx_output_actual_status_o = rx_valid_out_reg;

endmodule

`default_nettype wire

// file: verilog/sync2.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none

module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] q_reg;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			meta_reg <= '0;
			q_reg    <= '0;
		end else begin
			meta_reg <= d_i;
			q_reg    <= meta_reg;
		end
	end

	assign q_o = q_reg;

endmodule

`default_nettype wire

// file: dv/dp_status_checker_assertions.sv
// port assertions for the data path state reporting block
`timescale 1ns/100ps
`default_nettype none
`include "dp_status_consts.svh"

module dp_status_checker #(
	parameter int LANES      = 8,
	parameter int PATH_LANES = 2
) (
	input  wire logic               clk_i,
	input  wire logic               srst_i,
	input  wire logic               module_is_ready_term_i,
	input  wire logic               low_power_signal_i,
	input  wire logic [LANES-1:0]   lane_deinit_request_i,
	input  wire logic [LANES-1:0]   rx_output_mute_ctrl_i,
	input  wire logic [LANES-1:0]   auto_squelch_en_i,
	input  wire logic [LANES-1:0]   squelch_cond_i,
	input  wire logic [LANES-1:0]   state_changed_flag_clr_i,
	input  wire logic [LANES-1:0]   rx_valid_out_o,
	input  wire logic [LANES-1:0]   rx_output_actual_status_o,
	input  wire logic [LANES-1:0]   tx_output_enable_o,
	input  wire logic [LANES*4-1:0] lane_current_state_field_o,
	input  wire logic [LANES-1:0]   state_changed_flag_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	logic [3:0] code0;
	logic       go0;
	assign code0 = lane_current_state_field_o[3:0];
	assign go0 = ~|lane_deinit_request_i[PATH_LANES-1:0] && module_is_ready_term_i
		&& !low_power_signal_i;

	// past values taken during a reset are not trusted
	chk_flag_sticky: assert property (
		!$past(srst_i) |-> ($past(state_changed_flag_o) & ~state_changed_flag_o
		& ~$past(state_changed_flag_clr_i)) == '0)
		else $error("state changed flag dropped without a clear");
	chk_lane_pairing: assert property (
		code0 == lane_current_state_field_o[4*PATH_LANES-1 -: 4]
		&& state_changed_flag_o[0] == state_changed_flag_o[PATH_LANES-1])
		else $error("lanes of one path disagree");
	chk_rx_mute: assert property (
		!$past(srst_i) |-> (rx_valid_out_o & $past(rx_output_mute_ctrl_i)) == '0)
		else $error("muted rx lane still valid");
	chk_rx_status: assert property (
		rx_output_actual_status_o == rx_valid_out_o)
		else $error("rx status differs from rx output");
	chk_squelch_mutes: assert property (
		(auto_squelch_en_i[0] && squelch_cond_i[0])[*4] |=> !rx_valid_out_o[0])
		else $error("squelch condition left rx output valid");
	chk_ground_quiet: assert property (
		code0 == `DP_CODE_GROUND && $past(code0) == `DP_CODE_GROUND
		|-> tx_output_enable_o[PATH_LANES-1:0] == '0)
		else $error("tx enabled in ground state");
	chk_deinit_holds: assert property (
		(lane_deinit_request_i[0] && code0 == `DP_CODE_GROUND)[*6] |=> code0 == `DP_CODE_GROUND)
		else $error("path left ground despite deinit request");
	chk_ground_exit: assert property (
		(code0 == `DP_CODE_GROUND && go0)[*3] |-> ##[1:4] code0 == `DP_CODE_INITIALIZING)
		else $error("path did not leave ground");
	chk_flag_steady: assert property (
		!$past(srst_i) && $rose(state_changed_flag_o[0]) |-> ##[1:3] (code0 == `DP_CODE_GROUND
		|| code0 == `DP_CODE_ACTIVATED || code0 == `DP_CODE_INITIALIZED))
		else $error("flag raised outside a steady state");

	cov_flag: cover property ($rose(state_changed_flag_o[0]));
	cov_active: cover property (code0 == `DP_CODE_ACTIVATED);
	cov_rx: cover property ($rose(rx_valid_out_o[0]));
endmodule

bind data_path_state_reporting dp_status_checker #(
	.LANES(LANES),
	.PATH_LANES(PATH_LANES)
) u_dp_status_checker (.*);
`default_nettype wire

// file: dv/path_electronics_model.sv
// model of the path electronics finishing each transient state
`timescale 1ns/100ps
`default_nettype none
`include "dp_status_consts.svh"

module path_electronics_model #(
	parameter int LANES      = 4,
	parameter int PATH_LANES = 2
) (
	input  wire logic               clk_i,
	input  wire logic               slow_i,
	input  wire logic [LANES*4-1:0] field_i,
	output logic      [LANES-1:0]   init_done_o,
	output logic      [LANES-1:0]   deinit_done_o,
	output logic      [LANES-1:0]   turn_on_done_o,
	output logic      [LANES-1:0]   turn_off_done_o
);
	// work time counts from the reported code, so no transient is too short to be shown
	for (genvar p = 0; p < LANES; p = p + PATH_LANES) begin : g_path
		logic [3:0] code;
		logic [3:0] last = 4'h0;
		int         held = 0;
		logic       fin;
		assign code = field_i[4*p+3 -: 4];
		assign fin = held >= (slow_i ? 20 : 3);
		always @(posedge clk_i) begin
			last <= code;
			held <= (code === last) ? held + 1 : 0;
		end
		assign init_done_o[p +: PATH_LANES] = {PATH_LANES{fin && code == `DP_CODE_INITIALIZING}};
		assign deinit_done_o[p +: PATH_LANES] = {PATH_LANES{fin && code == `DP_CODE_DEINIT}};
		assign turn_on_done_o[p +: PATH_LANES] = {PATH_LANES{fin && code == `DP_CODE_TURNING_ON}};
		assign turn_off_done_o[p +: PATH_LANES] = {PATH_LANES{fin && code == `DP_CODE_TURNING_OFF}};
	end
endmodule
`default_nettype wire

// file: dv/data_path_state_reporting_test.sv
// self-checking bench for the data path state reporting block
`timescale 1ns/100ps
`default_nettype none
`include "dp_status_consts.svh"

module data_path_state_reporting_test;
	logic        clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        ready = 1'b1;
	logic        lowp = 1'b1;
	logic        slow = 1'b0;
	logic [3:0]  req = 4'hF, txoff = 4'h0, txsq = 4'h0, mute = 4'h0, asq = 4'h0, clr = 4'h0;
	logic [3:0]  rxin = 4'h0, sqc = 4'h0, mt_off = 4'h0, mt_on = 4'h0;
	logic [3:0]  mt_init = 4'h2, mt_deinit = 4'h2;
	logic [3:0]  idone, ddone, ondone, offdone, rxout, rxstat, txen, flag;
	logic [15:0] field;
	logic [3:0]  seen = `DP_CODE_GROUND;
	logic [3:0]  exp_q[$];
	logic [31:0] seed = 32'h0000C52B;
	int          errors = 0;
	int          total_checks = 0;

	initial forever #25 clk_i = ~clk_i;

	data_path_state_reporting #(.LANES(4), .PATH_LANES(2), .SHORT_CYC(8)) u_data_path_state_reporting (
		.clk_i(clk_i), .srst_i(srst_i), .module_is_ready_term_i(ready), .low_power_signal_i(lowp),
		.lane_deinit_request_i(req), .tx_output_off_ctrl_i(txoff), .tx_forced_squelch_ctrl_i(txsq),
		.rx_output_mute_ctrl_i(mute), .auto_squelch_en_i(asq), .state_changed_flag_clr_i(clr),
		.max_time_init_i(mt_init), .max_time_deinit_i(mt_deinit), .max_time_turn_on_i(mt_on),
		.max_time_turn_off_i(mt_off), .init_done_i(idone), .deinit_done_i(ddone),
		.turn_on_done_i(ondone), .turn_off_done_i(offdone), .rx_valid_in_i(rxin),
		.squelch_cond_i(sqc), .rx_valid_out_o(rxout), .rx_output_actual_status_o(rxstat),
		.tx_output_enable_o(txen), .lane_current_state_field_o(field), .state_changed_flag_o(flag));
	path_electronics_model #(.LANES(4), .PATH_LANES(2)) u_path_electronics_model (
		.clk_i(clk_i), .slow_i(slow), .field_i(field), .init_done_o(idone),
		.deinit_done_o(ddone), .turn_on_done_o(ondone), .turn_off_done_o(offdone));

	task automatic check(input logic [15:0] got, input logic [15:0] want, input string what);
		total_checks++;
		if (got !== want) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, want, got);
		end
	endtask

	task automatic close_out();
		if (errors == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		t = t ^ (t << 5);
		return t;
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#5;
	endtask

	task automatic wait_code(input logic [3:0] code);
		int i;
		for (i = 0; i < 400 && field[3:0] !== code; i++) cyc(1);
		if (i == 400) begin
			check(16'(field[3:0]), 16'(code), "wait_field");
			close_out();
		end
	endtask

	// random rx pins, mutes and squelch; live marks lanes past first init
	task automatic rx_round(input logic [3:0] live);
		logic [31:0] r;
		for (int n = 0; n < 6; n++) begin
			seed = xorshift(seed);
			r = seed;
			{rxin, mute, asq, sqc} = r[15:0];
			cyc(5);
			check(16'(rxout), 16'(rxin & live & ~mute & ~(asq & sqc)), "rx_out");
			check(16'(rxstat), 16'(rxin & live & ~mute & ~(asq & sqc)), "rx_status");
		end
	endtask

	// lane 0 code changes are matched against the planned order
	initial forever begin
		@(posedge clk_i);
		#2;
		if (!srst_i && field[3:0] !== seen) begin
			seen = field[3:0];
			if (exp_q.size() == 0) check(16'(seen), 16'h0, "field_extra");
			else check(16'(seen), 16'(exp_q.pop_front()), "field_order");
		end
	end

	initial begin
		cyc(5);
		srst_i = 1'b0;
		cyc(1);
		check(field, 16'h1111, "field_reset");
		check(16'(flag), 16'h0, "flag_reset");
		rx_round(4'h0);
		check(field, 16'h1111, "held_low_power");
		exp_q = '{`DP_CODE_INITIALIZING, `DP_CODE_INITIALIZED};
		txoff = 4'b0101;
		req = 4'h0;
		lowp = 1'b0;
		wait_code(`DP_CODE_INITIALIZED);
		cyc(1);
		check(field, 16'h7777, "field_init");
		check(16'(flag), 16'hF, "flag_init");
		rx_round(4'hF);
		clr = 4'hF;
		cyc(1);
		clr = 4'h0;
		check(16'(flag), 16'h0, "flag_clear");
		// zero turn-on time code gives no indication
		exp_q = '{`DP_CODE_TURNING_ON, `DP_CODE_ACTIVATED};
		txoff = 4'b0100;
		wait_code(`DP_CODE_ACTIVATED);
		cyc(2);
		check(16'(flag), 16'h0, "flag_turn_on");
		check(field, 16'h7744, "field_active");
		rx_round(4'hF);
		// one write takes both paths down, the short initialized visit unshown
		mt_off = 4'h3;
		exp_q = '{`DP_CODE_TURNING_OFF, `DP_CODE_DEINIT, `DP_CODE_GROUND};
		req = 4'hF;
		wait_code(`DP_CODE_GROUND);
		cyc(2);
		check(field, 16'h1111, "field_ground");
		check(16'(flag), 16'hF, "flag_ground");
		check(16'(txen), 16'h0, "tx_ground");
		// slow electronics; flags left set must survive the moves to initializing and initialized
		slow = 1'b1;
		txoff = 4'h0;
		txsq = 4'b0101;
		// insignificant init time: no new indication, so the old flags must survive
		mt_init = 4'h0;
		exp_q = '{`DP_CODE_INITIALIZING, `DP_CODE_INITIALIZED};
		req = 4'h0;
		wait_code(`DP_CODE_INITIALIZED);
		cyc(2);
		check(16'(flag), 16'hF, "flag_kept");
		exp_q = '{`DP_CODE_DEINIT, `DP_CODE_GROUND};
		ready = 1'b0;
		wait_code(`DP_CODE_GROUND);
		cyc(30);
		check(field, 16'h1111, "held_not_ready");
		check(16'(exp_q.size()), 16'h0, "field_left");
		close_out();
	end
endmodule
`default_nettype wire
